/* inc/ees_cfg.svh */
// Register map, field positions and reset values of the ECC status block
`ifndef EES_CFG_SVH
`define EES_CFG_SVH

// Bus, register index and counter widths
`define EES_ADDR_W 12
`define EES_DATA_W 32
`define EES_IDX_W 10
`define EES_CNT_W 4

// Register indices; byte address is four times the index
`define EES_IDX_CFG 10'h082
`define EES_IDX_STATUS 10'h090
`define EES_IDX_ERR_ADDR 10'h091
`define EES_IDX_DROP_ADDR 10'h092
`define EES_IDX_IRQ_STS 10'h093

// Configuration word fields
`define EES_CFG_GEN_SBE 0
`define EES_CFG_GEN_DBE 1
`define EES_CFG_IRQ_EN 2
`define EES_CFG_MASK_LO 3
`define EES_CFG_MASK_HI 6
`define EES_CFG_CLR 7

// Interrupt source count: single, double, dropped fix, hard interface
`define EES_NSRC 4
// Counted events: single, double, dropped fix
`define EES_NCNT 3

// Reset values
`define EES_FLAG_RST 1'b0
`define EES_ADDR_RST 32'h0000_0000
`define EES_SRC_RST 4'h0
`define EES_WORD_ZERO 32'h0000_0000

// AXI responses
`define EES_RESP_OKAY 2'b00
`define EES_RESP_SLVERR 2'b10

`endif

/* inc/ees_pkg.sv */
// Types shared by the ECC status block modules
`include "ees_cfg.svh"
package ees_pkg;

  // Events from the ECC checker and correction scheduler
  typedef struct packed {
    logic sbe;
    logic dbe;
    logic [`EES_DATA_W-1:0] err_addr;
    logic fix_req;
    logic fix_ready;
    logic [`EES_DATA_W-1:0] fix_addr;
    logic hmi;
  } ees_evt_s;

  // Register access request from the bus slave
  typedef struct packed {
    logic wr;
    logic [`EES_ADDR_W-1:0] waddr;
    logic [`EES_DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic rd;
    logic [`EES_ADDR_W-1:0] raddr;
  } ees_reg_req_s;

  // Bus slave state
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [`EES_ADDR_W-1:0] waddr;
    logic [`EES_DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [`EES_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } ees_axil_state_s;

  // Configuration fields kept by the core
  typedef struct packed {
    logic [`EES_NSRC-1:0] mask;
    logic irq_en;
    logic gen_dbe;
    logic gen_sbe;
  } ees_cfg_s;

  // Core state
  typedef struct packed {
    ees_cfg_s cfg;
    logic intr;
    logic sbe;
    logic dbe;
    logic drop;
    logic [`EES_DATA_W-1:0] err_addr;
    logic [`EES_DATA_W-1:0] drop_addr;
    logic [`EES_NSRC-1:0] irq_sts;
    logic irq;
  } ees_core_state_s;

endpackage

/* rtl/ees_wrap_cnt.sv */
// Wrapping event counter
`timescale 1ns/1ps
`include "ees_cfg.svh"
module ees_wrap_cnt #(
  parameter int W = `EES_CNT_W
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_inc,
  output logic [W-1:0] o_count
);
  import ees_pkg::*;

  // Whole state of the counter
  typedef struct packed {
    logic [W-1:0] cnt;
  } ees_cnt_state_s;

  ees_cnt_state_s st_reg;
  ees_cnt_state_s st_next;

  // Step by one; the carry out is dropped so the count wraps
  always_comb begin
    st_next = st_reg;
    if (i_inc) begin
      st_next.cnt = st_reg.cnt + W'(1);
    end
  end

  // Only reset zeroes the count
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_count = st_reg.cnt;
endmodule

/* rtl/ees_axil_slave.sv */
// AXI4-Lite slave front end for the ECC status registers
`timescale 1ns/1ps
`include "ees_cfg.svh"
module ees_axil_slave (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [`EES_ADDR_W-1:0] i_s_axil_awaddr,
  input wire logic i_s_axil_awvalid,
  output logic o_s_axil_awready,
  input wire logic [`EES_DATA_W-1:0] i_s_axil_wdata,
  input wire logic [3:0] i_s_axil_wstrb,
  input wire logic i_s_axil_wvalid,
  output logic o_s_axil_wready,
  output logic [1:0] o_s_axil_bresp,
  output logic o_s_axil_bvalid,
  input wire logic i_s_axil_bready,
  input wire logic [`EES_ADDR_W-1:0] i_s_axil_araddr,
  input wire logic i_s_axil_arvalid,
  output logic o_s_axil_arready,
  output logic [`EES_DATA_W-1:0] o_s_axil_rdata,
  output logic [1:0] o_s_axil_rresp,
  output logic o_s_axil_rvalid,
  input wire logic i_s_axil_rready,
  output ees_pkg::ees_reg_req_s o_req,
  input wire logic i_wr_hit,
  input wire logic i_rd_hit,
  input wire logic [`EES_DATA_W-1:0] i_rdata
);
  import ees_pkg::*;

  ees_axil_state_s st_reg;
  ees_axil_state_s st_next;
  logic do_wr;
  logic do_rd;

  // One write and one read in flight; each address/data held until used
  always_comb begin
    st_next = st_reg;
    o_s_axil_awready = !st_reg.aw_got && !st_reg.bvalid;
    o_s_axil_wready = !st_reg.w_got && !st_reg.bvalid;
    o_s_axil_arready = !st_reg.rvalid;
    // Address and data may come in either order
    if (i_s_axil_awvalid && o_s_axil_awready) begin
      st_next.aw_got = 1'b1;
      st_next.waddr = i_s_axil_awaddr;
    end
    if (i_s_axil_wvalid && o_s_axil_wready) begin
      st_next.w_got = 1'b1;
      st_next.wdata = i_s_axil_wdata;
      st_next.wstrb = i_s_axil_wstrb;
    end
    // Execute once both halves are in
    do_wr = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
    if (do_wr) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = i_wr_hit ? `EES_RESP_OKAY : `EES_RESP_SLVERR;
    end else if (st_reg.bvalid && i_s_axil_bready) begin
      st_next.bvalid = 1'b0;
    end
    // Reads sample the register word on the address handshake
    do_rd = i_s_axil_arvalid && o_s_axil_arready;
    if (do_rd) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = i_rd_hit ? i_rdata : `EES_WORD_ZERO;
      st_next.rresp = i_rd_hit ? `EES_RESP_OKAY : `EES_RESP_SLVERR;
    end else if (st_reg.rvalid && i_s_axil_rready) begin
      st_next.rvalid = 1'b0;
    end
    o_req.wr = do_wr;
    o_req.waddr = st_reg.waddr;
    o_req.wdata = st_reg.wdata;
    o_req.wstrb = st_reg.wstrb;
    o_req.rd = do_rd;
    o_req.raddr = i_s_axil_araddr;
  end

  // State register
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_s_axil_bvalid = st_reg.bvalid;
  assign o_s_axil_bresp = st_reg.bresp;
  assign o_s_axil_rvalid = st_reg.rvalid;
  assign o_s_axil_rdata = st_reg.rdata;
  assign o_s_axil_rresp = st_reg.rresp;
endmodule

/* rtl/ees_top.sv */
// ECC error status, counters, captured addresses and interrupt
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`include "ees_cfg.svh"
module ees_top (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // AXI4-Lite register port
  input wire logic [`EES_ADDR_W-1:0] i_s_axil_awaddr,
  input wire logic i_s_axil_awvalid,
  output logic o_s_axil_awready,
  input wire logic [`EES_DATA_W-1:0] i_s_axil_wdata,
  input wire logic [3:0] i_s_axil_wstrb,
  input wire logic i_s_axil_wvalid,
  output logic o_s_axil_wready,
  output logic [1:0] o_s_axil_bresp,
  output logic o_s_axil_bvalid,
  input wire logic i_s_axil_bready,
  input wire logic [`EES_ADDR_W-1:0] i_s_axil_araddr,
  input wire logic i_s_axil_arvalid,
  output logic o_s_axil_arready,
  output logic [`EES_DATA_W-1:0] o_s_axil_rdata,
  output logic [1:0] o_s_axil_rresp,
  output logic o_s_axil_rvalid,
  input wire logic i_s_axil_rready,
  // Events from checker and correction scheduler
  input wire ees_pkg::ees_evt_s i_evt,
  // Error injection enables for the write path
  output logic o_gen_sbe,
  output logic o_gen_dbe,
  // Level interrupt
  output logic o_irq
);
  import ees_pkg::*;

  // Register request from the bus front end
  ees_reg_req_s req;
  // Decode results
  logic wr_hit;
  logic rd_hit;
  logic [`EES_DATA_W-1:0] rdata;
  // Write index and read index
  logic [`EES_IDX_W-1:0] widx;
  logic [`EES_IDX_W-1:0] ridx;

  // Whole state of the core
  ees_core_state_s st_reg;
  ees_core_state_s st_next;

  // Qualified events, taken straight from the inputs; each cycle held high counts once
  logic ev_sbe;
  logic ev_dbe;
  logic ev_drop;
  logic ev_hmi;
  // Source vector in mask bit order
  logic [`EES_NSRC-1:0] src;
  // Counted events and their counts
  logic [`EES_NCNT-1:0] cnt_inc;
  logic [`EES_CNT_W-1:0] cnt [`EES_NCNT];

  // Control decodes for this cycle
  logic cfg_wr;
  logic clr;
  logic sts_w1c;
  logic [`EES_NSRC-1:0] w1c_bits;
  logic [`EES_NSRC-1:0] pend;

  // Bus slave; answers are built from decode below
  ees_axil_slave u_axil (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_s_axil_awaddr(i_s_axil_awaddr),
    .i_s_axil_awvalid(i_s_axil_awvalid),
    .o_s_axil_awready(o_s_axil_awready),
    .i_s_axil_wdata(i_s_axil_wdata),
    .i_s_axil_wstrb(i_s_axil_wstrb),
    .i_s_axil_wvalid(i_s_axil_wvalid),
    .o_s_axil_wready(o_s_axil_wready),
    .o_s_axil_bresp(o_s_axil_bresp),
    .o_s_axil_bvalid(o_s_axil_bvalid),
    .i_s_axil_bready(i_s_axil_bready),
    .i_s_axil_araddr(i_s_axil_araddr),
    .i_s_axil_arvalid(i_s_axil_arvalid),
    .o_s_axil_arready(o_s_axil_arready),
    .o_s_axil_rdata(o_s_axil_rdata),
    .o_s_axil_rresp(o_s_axil_rresp),
    .o_s_axil_rvalid(o_s_axil_rvalid),
    .i_s_axil_rready(i_s_axil_rready),
    .o_req(req),
    .i_wr_hit(wr_hit),
    .i_rd_hit(rd_hit),
    .i_rdata(rdata)
  );

  // Word indices; the low two address bits select bytes, ignored here
  assign widx = req.waddr[`EES_ADDR_W-1:2];
  assign ridx = req.raddr[`EES_ADDR_W-1:2];

  // Event qualification
  always_comb begin
    ev_sbe = i_evt.sbe;
    ev_dbe = i_evt.dbe;
    // A fix request refused by a full queue is lost, not delayed
    ev_drop = i_evt.fix_req && !i_evt.fix_ready;
    ev_hmi = i_evt.hmi;
    // Order matches mask bits: single, double, dropped, hard interface
    src = {ev_hmi, ev_drop, ev_dbe, ev_sbe};
    // Hard interface events raise interrupts but are not counted
    cnt_inc = {ev_drop, ev_dbe, ev_sbe};
  end

  // Write-side address decode; read-only words accept and ignore writes
  always_comb begin
    if (widx == `EES_IDX_CFG) begin
      wr_hit = 1'b1;
    end else if (widx == `EES_IDX_STATUS) begin
      wr_hit = 1'b1;
    end else if (widx == `EES_IDX_ERR_ADDR) begin
      wr_hit = 1'b1;
    end else if (widx == `EES_IDX_DROP_ADDR) begin
      wr_hit = 1'b1;
    end else if (widx == `EES_IDX_IRQ_STS) begin
      wr_hit = 1'b1;
    end else begin
      // Unmapped: slave answers with an error
      wr_hit = 1'b0;
    end
  end

  // Read mux; pure selection so reading disturbs nothing
  always_comb begin
    rd_hit = 1'b1;
    rdata = `EES_WORD_ZERO;
    if (ridx == `EES_IDX_CFG) begin
      // Clear bit always reads back zero
      rdata[`EES_CFG_GEN_SBE] = st_reg.cfg.gen_sbe;
      rdata[`EES_CFG_GEN_DBE] = st_reg.cfg.gen_dbe;
      rdata[`EES_CFG_IRQ_EN] = st_reg.cfg.irq_en;
      rdata[`EES_CFG_MASK_HI:`EES_CFG_MASK_LO] = st_reg.cfg.mask;
    end else if (ridx == `EES_IDX_STATUS) begin
      // Upper half stays zero
      rdata[15:0] = {cnt[2], cnt[1], cnt[0], st_reg.drop, st_reg.dbe,
                     st_reg.sbe, st_reg.intr};
    end else if (ridx == `EES_IDX_ERR_ADDR) begin
      rdata = st_reg.err_addr;
    end else if (ridx == `EES_IDX_DROP_ADDR) begin
      rdata = st_reg.drop_addr;
    end else if (ridx == `EES_IDX_IRQ_STS) begin
      // Same layout as the mask field
      rdata[`EES_CFG_MASK_HI:`EES_CFG_MASK_LO] = st_reg.irq_sts;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Next state: software writes first, then clears, then events
  always_comb begin
    st_next = st_reg;
    // Only byte lane 0 carries configuration bits
    cfg_wr = req.wr && (widx == `EES_IDX_CFG) && req.wstrb[0];
    // Clear is a one-cycle strobe, never stored
    clr = cfg_wr && req.wdata[`EES_CFG_CLR];
    sts_w1c = req.wr && (widx == `EES_IDX_IRQ_STS) && req.wstrb[0];
    w1c_bits = req.wdata[`EES_CFG_MASK_HI:`EES_CFG_MASK_LO];

    if (cfg_wr) begin
      st_next.cfg.gen_sbe = req.wdata[`EES_CFG_GEN_SBE];
      st_next.cfg.gen_dbe = req.wdata[`EES_CFG_GEN_DBE];
      st_next.cfg.irq_en = req.wdata[`EES_CFG_IRQ_EN];
      st_next.cfg.mask = req.wdata[`EES_CFG_MASK_HI:`EES_CFG_MASK_LO];
    end

    // Write one to drop an interrupt cause
    if (sts_w1c) begin
      st_next.irq_sts = st_reg.irq_sts & ~w1c_bits;
    end

    // Clear wipes status, addresses and interrupt; counts survive
    if (clr) begin
      st_next.intr = `EES_FLAG_RST;
      st_next.sbe = `EES_FLAG_RST;
      st_next.dbe = `EES_FLAG_RST;
      st_next.drop = `EES_FLAG_RST;
      st_next.err_addr = `EES_ADDR_RST;
      st_next.drop_addr = `EES_ADDR_RST;
      st_next.irq_sts = `EES_SRC_RST;
    end

    // Events set after clears so a same-cycle event is never lost
    if (ev_sbe) begin
      st_next.sbe = 1'b1;
    end
    if (ev_dbe) begin
      st_next.dbe = 1'b1;
    end
    if (ev_drop) begin
      st_next.drop = 1'b1;
    end
    st_next.irq_sts = st_next.irq_sts | src;

    // Either error kind overwrites the captured address
    if (ev_sbe || ev_dbe) begin
      st_next.err_addr = i_evt.err_addr;
    end
    if (ev_drop) begin
      st_next.drop_addr = i_evt.fix_addr;
    end

    // Mask bit 1 suppresses its source; enable gates the whole output
    pend = st_next.irq_sts & ~st_next.cfg.mask;
    st_next.irq = st_next.cfg.irq_en && (|pend);
    // Record that the interrupt fired; read-only to software
    if (st_next.irq) begin
      st_next.intr = 1'b1;
    end
  end

  // Core state register
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Three wrapping counters; clear leaves them alone by design
  for (genvar g = 0; g < `EES_NCNT; g++) begin : g_cnt
    ees_wrap_cnt #(
      .W(`EES_CNT_W)
    ) u_cnt (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_inc(cnt_inc[g]),
      .o_count(cnt[g])
    );
  end

  // Outputs straight from flip-flops
  assign o_gen_sbe = st_reg.cfg.gen_sbe;
  assign o_gen_dbe = st_reg.cfg.gen_dbe;
  assign o_irq = st_reg.irq;

  // Status flags and addresses change only above; no read path writes
  // back into state, which keeps polling harmless
endmodule

/* bench/ees_chk.sv */
// Port checker for the ECC status block, bound to its top
`timescale 1ns/1ps
`include "ees_cfg.svh"
module ees_chk (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_s_axil_awvalid,
  input wire logic o_s_axil_awready,
  input wire logic i_s_axil_wvalid,
  input wire logic o_s_axil_wready,
  input wire logic [1:0] o_s_axil_bresp,
  input wire logic o_s_axil_bvalid,
  input wire logic i_s_axil_bready,
  input wire logic i_s_axil_arvalid,
  input wire logic o_s_axil_arready,
  input wire logic [`EES_DATA_W-1:0] o_s_axil_rdata,
  input wire logic [1:0] o_s_axil_rresp,
  input wire logic o_s_axil_rvalid,
  input wire ees_pkg::ees_evt_s i_evt,
  input wire logic o_gen_sbe,
  input wire logic o_gen_dbe,
  input wire logic o_irq
);
  import ees_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Any event able to raise the interrupt
  logic evt_any;
  assign evt_any = i_evt.sbe | i_evt.dbe | i_evt.hmi |
                   (i_evt.fix_req & ~i_evt.fix_ready);
  // Address and data taken at one edge
  sequence wr_take_s;
    i_s_axil_awvalid && o_s_axil_awready &&
    i_s_axil_wvalid && o_s_axil_wready;
  endsequence
  // Response two edges later
  sequence wr_done_s;
    ##2 o_s_axil_bvalid;
  endsequence
  wr_resp_a: assert property (wr_take_s |-> wr_done_s)
    else $error("write response late");
  rd_resp_a: assert property (i_s_axil_arvalid && o_s_axil_arready
    |=> o_s_axil_rvalid) else $error("read data late");
  b_hold_a: assert property (o_s_axil_bvalid && !i_s_axil_bready
    |=> o_s_axil_bvalid && $stable(o_s_axil_bresp))
    else $error("write response dropped");
  ar_block_a: assert property (o_s_axil_rvalid |-> !o_s_axil_arready)
    else $error("read accepted while busy");
  aw_block_a: assert property (o_s_axil_bvalid |->
    !o_s_axil_awready && !o_s_axil_wready)
    else $error("write accepted while busy");
  err_data_a: assert property (o_s_axil_rvalid &&
    o_s_axil_rresp == `EES_RESP_SLVERR |-> o_s_axil_rdata == '0)
    else $error("unmapped read data not zero");
  irq_rise_a: assert property ($rose(o_irq) |->
    $past(evt_any) || $rose(o_s_axil_bvalid))
    else $error("interrupt without cause");
  irq_fall_a: assert property ($fell(o_irq) |->
    $rose(o_s_axil_bvalid)) else $error("interrupt lost");
  gen_cfg_a: assert property ($changed({o_gen_sbe, o_gen_dbe})
    |-> $rose(o_s_axil_bvalid)) else $error("injection enable moved");
endmodule
bind ees_top ees_chk u_chk (.*);

/* bench/tb_top.sv */
// Self-checking bench for the ECC status block
`timescale 1ns/1ps
`include "ees_cfg.svh"
module tb_top;
  import ees_pkg::*;
  localparam logic [11:0] A_CFG = 12'h208, A_STS = 12'h240;
  localparam logic [11:0] A_EA = 12'h244, A_DA = 12'h248;
  localparam logic [11:0] A_IRQ = 12'h24c;
  logic clk, rst, awv, wv, bry, arv, rry;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdata, d;
  logic [3:0] ws;
  logic [1:0] bresp, rresp, r;
  logic awr, wrd, bv, arr, rv, gs, gd, irq;
  ees_evt_s evt;
  int miscompares, n_tests, i;
  ees_top dut (.i_sys_clk(clk), .i_rst(rst),
    .i_s_axil_awaddr(awa), .i_s_axil_awvalid(awv),
    .o_s_axil_awready(awr), .i_s_axil_wdata(wd), .i_s_axil_wstrb(ws),
    .i_s_axil_wvalid(wv), .o_s_axil_wready(wrd),
    .o_s_axil_bresp(bresp), .o_s_axil_bvalid(bv),
    .i_s_axil_bready(bry), .i_s_axil_araddr(ara),
    .i_s_axil_arvalid(arv), .o_s_axil_arready(arr),
    .o_s_axil_rdata(rdata), .o_s_axil_rresp(rresp),
    .o_s_axil_rvalid(rv), .i_s_axil_rready(rry), .i_evt(evt),
    .o_gen_sbe(gs), .o_gen_dbe(gd), .o_irq(irq));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Write one word; bready raised after sl cycles
  task automatic wr(input logic [11:0] a, input logic [31:0] v,
                    input logic [1:0] er, input int sl = 0);
    int n;
    @(posedge clk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= (sl == 0);
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (n + 1 == sl) bry <= 1'b1;
      if (bv && bry) break;
    end
    if (n == 20) begin
      miscompares++;
      wrap_up();
    end
    bry <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask
  // Read one word
  task automatic rdw(input logic [11:0] a);
    int n;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    if (n == 20) begin
      miscompares++;
      wrap_up();
    end
    d = rdata;
    r = rresp;
    rry <= 1'b0;
  endtask
  // Read and compare, mapped word expected
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    rdw(a);
    chk(d, e);
    chk(32'(r), 32'(`EES_RESP_OKAY));
  endtask
  // Event pulse: k = {served fix, hmi, drop, dbe, sbe}
  task automatic pulse(input logic [4:0] k, input logic [31:0] a,
                       input int cyc = 1);
    ees_evt_s idle;
    idle = '0;
    idle.fix_ready = 1'b1;
    @(posedge clk);
    evt.sbe <= k[0];
    evt.dbe <= k[1];
    evt.fix_req <= k[2] | k[4];
    evt.fix_ready <= ~k[2];
    evt.hmi <= k[3];
    evt.err_addr <= a;
    evt.fix_addr <= a;
    repeat (cyc) @(posedge clk);
    // One assignment so the idle word lands in a single update
    evt <= idle;
  endtask
  // Status and both address words clear out of reset, interrupt low
  task automatic t_reset;
    rchk(A_STS, 0);
    rchk(A_EA, 0);
    rchk(A_DA, 0);
    chk(32'(irq), 0);
  endtask
  // Single error, sticky flag, repeated read
  task automatic t_sbe;
    pulse(5'h01, 32'hdead_0010);
    rchk(A_STS, 32'h12);
    rchk(A_STS, 32'h12);
    rchk(A_EA, 32'hdead_0010);
    chk(32'(irq), 0);
  endtask
  // Counters wrap, latest addresses, drops only on back-pressure
  task automatic t_count;
    for (i = 0; i < 15; i++) pulse(5'h01, 32'h0);
    for (i = 0; i < 17; i++) pulse(5'h02, 32'h100 + i);
    pulse(5'h04, 32'h2000, 3);
    pulse(5'h04, 32'h3000);
    pulse(5'h10, 32'h4000);
    rchk(A_STS, 32'h410e);
    rchk(A_EA, 32'h110);
    rchk(A_DA, 32'h3000);
  endtask
  // Enable, masks, per-source status, read-only status word
  task automatic t_irq;
    wr(A_CFG, 32'h04, `EES_RESP_OKAY, 3);
    chk(32'(irq), 1);
    rchk(A_STS, 32'h410f);
    rchk(A_IRQ, 32'h38);
    wr(A_CFG, 32'h3c, `EES_RESP_OKAY);
    chk(32'(irq), 0);
    pulse(5'h08, 32'h0);
    @(posedge clk);
    chk(32'(irq), 1);
    wr(A_CFG, 32'h7c, `EES_RESP_OKAY);
    chk(32'(irq), 0);
    wr(A_IRQ, 32'h78, `EES_RESP_OKAY);
    wr(A_CFG, 32'h04, `EES_RESP_OKAY);
    chk(32'(irq), 0);
    wr(A_STS, 32'h0, `EES_RESP_OKAY);
    rchk(A_STS, 32'h410f);
  endtask
  // Software clear, injection enables, unmapped word
  task automatic t_clear;
    wr(A_CFG, 32'h84, `EES_RESP_OKAY);
    rchk(A_STS, 32'h4100);
    rchk(A_EA, 0);
    rchk(A_DA, 0);
    rchk(A_CFG, 32'h04);
    wr(A_CFG, 32'h03, `EES_RESP_OKAY);
    chk(32'({gs, gd}), 32'h3);
    rdw(12'h300);
    chk(d, 0);
    chk(32'(r), 32'(`EES_RESP_SLVERR));
    wr(12'h300, 32'h1, `EES_RESP_SLVERR);
  endtask
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Reset, then scenarios in order
  initial begin
    rst = 1'b1;
    {awv, wv, bry, arv, rry} = '0;
    awa = '0;
    ara = '0;
    wd = '0;
    ws = 4'hf;
    evt = '0;
    evt.fix_ready = 1'b1;
    miscompares = 0;
    n_tests = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_sbe();
    t_count();
    t_irq();
    t_clear();
    wrap_up();
  end
endmodule
